// ---- src/converter_status_registers.sv ----
// Purpose: Read-only status register bank of a buck-boost converter controller.
// Assumes: Analog conditions arrive asynchronously; mode controls come from clk_i logic.
// Notes:   Images refresh every cycle; a read returns the image one cycle later.
`timescale 1ns/1ps

// Operation
// RULE1 - ADC done shown only in one-shot mode
// RULE2 - Input current loop bit from pin or target
// RULE3 - Input voltage loop bit, forward or reverse
// RULE4 - Watchdog expired bit follows host timer
// RULE5 - Converter state code in low three bits
// RULE6 - Power good bit follows input power
// RULE7 - Thermistor region code in bits six to four
// RULE8 - Sync pin state code in bits five, four
// RULE9 - Reverse direction bit follows converter direction
// RULE10 - Input under-voltage bit follows protection
// RULE11 - Input over-voltage bit follows protection
// RULE12 - Battery over-current bit follows detection
// RULE13 - Battery over-voltage bit follows protection
// RULE14 - Thermal shutdown bit follows protection
// RULE15 - Driver supply fault bit when out of range
// RULE16 - Driver fault forced high, battery-only, ADC off
// RULE17 - Registers at 0x21 to 0x24, reset zero
// RULE18 - Watchdog flag latches rising edge, clears on read
// RULE19 - Writes ignored, reserved bits read zero
module converter_status_registers
   import conv_status_pkg::*;
(
   input  wire logic           clk_i, // System clock, 20 MHz.
   input  wire logic           srst_i, // Synchronous reset, active high.
   input  wire analog_status_s conditions_i, // Live analog conditions, asynchronous.
   input  wire logic           one_shot_mode_i, // ADC in one-shot conversion mode.
   input  wire logic           adc_enabled_i, // ADC enabled.
   input  wire host_access_s   host_i, // Host register access request.
   output logic [7:0]          rd_data_o, // Read data, registered.
   output logic                rd_valid_o, // Read data valid, one-cycle pulse.
   output logic                host_timer_interrupt_flag_o // Sticky watchdog flag.
);

   // Converter state codes outside the documented set read as not switching,
   // so a glitching analog encoder never shows a reserved code to the host.
   function automatic logic [2:0] clean_converter_state(input logic [2:0] code);
      case (code)
         CONV_CONSTANT_CURRENT, CONV_CV_FIRST, CONV_CV_SECOND, CONV_CV_THIRD: begin
            return code;
         end
         default: begin
            return CONV_NOT_SWITCHING;
         end
      endcase
   endfunction

   // Thermistor codes beyond hot are undefined and read as normal.
   function automatic logic [2:0] clean_thermistor_region(input logic [2:0] code);
      case (code)
         TS_WARM, TS_COOL, TS_COLD, TS_HOT: begin
            return code;
         end
         default: begin
            return TS_NORMAL;
         end
      endcase
   endfunction

   // The reserved sync code reads as no external clock.
   function automatic logic [1:0] clean_sync_state(input logic [1:0] code);
      case (code)
         SYNC_VALID_CLOCK, SYNC_PIN_FAULT: begin
            return code;
         end
         default: begin
            return SYNC_NO_CLOCK;
         end
      endcase
   endfunction

   // All state of the bank outside the synchroniser and the flag latch in one record.
   typedef struct packed {
      status_image_s image;                       // Four status register images.
      logic [7:0]    rd_data;                     // Captured read data.
      logic          rd_valid;                    // Read answer pulse.
   } bank_state_s;

   bank_state_s    state;       // Registered state.
   bank_state_s    next_state;  // Next state.
   analog_status_s live;        // Conditions after synchronisation.
   logic           flag_clear;  // Host reads the flag register.
   logic           flag;        // Sticky watchdog flag.
   logic [7:0]     flag_image;  // Flag register as read.

   // Every analog condition crosses through the three-stage filter. The cost is
   // four cycles of delay, far below any analog settling time.
   status_input_sync #(
      .WIDTH ($bits(analog_status_s))
   ) u_sync (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .async_i(conditions_i),
      .sync_o (live)
   );

   // A flag read is any accepted read of the flag offset.
   assign flag_clear = host_i.rd_en && (host_i.addr == ADDR_HOST_TIMER_FLAG); // RULE18

   // Sticky flag on a rising edge of the filtered watchdog status.
   host_timer_flag_latch u_flag (
      .clk_i                       (clk_i),
      .srst_i                      (srst_i),
      .status_bit_i                (live.host_timer_expired),
      .clear_i                     (flag_clear),
      .host_timer_interrupt_flag_o (flag)
   );

   // Flag register: only the watchdog flag is kept, other positions read zero.
   always_comb begin
      flag_image                 = REG_RESET_VALUE;
      flag_image[BIT_HOST_TIMER] = flag; // RULE18
   end

   // Build the register images and answer host reads.
   always_comb begin
      next_state = state;

      // Regulation state register; bits not written here stay zero.
      next_state.image.regulation_state_reg = REG_RESET_VALUE; // RULE19
      // Done is meaningless in continuous mode, so it is gated by the mode.
      next_state.image.regulation_state_reg[BIT_ADC_DONE] =
         live.adc_conversion_done & one_shot_mode_i; // RULE1
      // Either current limit source puts the loop in regulation.
      next_state.image.regulation_state_reg[BIT_INPUT_CURRENT] =
         live.hardware_current_limit_pin | live.programmed_input_current_target; // RULE2
      // Forward input limit or reverse system target drive the voltage loop.
      next_state.image.regulation_state_reg[BIT_INPUT_VOLTAGE] =
         live.forward_input_voltage_limit | live.reverse_system_voltage_target; // RULE3
      // The expired bit is a level that falls again in normal operation.
      next_state.image.regulation_state_reg[BIT_HOST_TIMER] = live.host_timer_expired; // RULE4
      next_state.image.regulation_state_reg[LSB_CONVERTER_STATE +: 3] =
         clean_converter_state(live.converter_state); // RULE5

      // Power and thermal register.
      next_state.image.power_thermal_state_reg = REG_RESET_VALUE; // RULE19
      next_state.image.power_thermal_state_reg[BIT_POWER_GOOD] = live.input_power_good; // RULE6
      next_state.image.power_thermal_state_reg[LSB_THERMISTOR +: 3] =
         clean_thermistor_region(live.thermistor_region); // RULE7

      // Sync and direction register.
      next_state.image.sync_direction_state_reg = REG_RESET_VALUE; // RULE19
      next_state.image.sync_direction_state_reg[LSB_SYNC_CLOCK +: 2] =
         clean_sync_state(live.external_sync_clock_pin); // RULE8
      next_state.image.sync_direction_state_reg[BIT_REVERSE] = live.reverse_direction; // RULE9

      // Protection fault register.
      next_state.image.protection_fault_state_reg = REG_RESET_VALUE; // RULE19
      next_state.image.protection_fault_state_reg[BIT_INPUT_UV] = live.input_undervoltage; // RULE10
      next_state.image.protection_fault_state_reg[BIT_INPUT_OV] = live.input_overvoltage; // RULE11
      next_state.image.protection_fault_state_reg[BIT_BATTERY_OC] = live.battery_overcurrent; // RULE12
      next_state.image.protection_fault_state_reg[BIT_BATTERY_OV] = live.battery_overvoltage; // RULE13
      next_state.image.protection_fault_state_reg[BIT_THERMAL_SHUTDOWN] = live.thermal_shutdown; // RULE14
      // Without the ADC nothing measures the driver supply on battery alone, so
      // the bit is pinned high rather than reporting a stale comparison.
      next_state.image.protection_fault_state_reg[BIT_DRIVER_SUPPLY] =
         live.gate_driver_supply_pin | // RULE15
         (live.battery_only_mode & ~adc_enabled_i); // RULE16

      // Reads answer one cycle after the strobe; data holds until the next read.
      next_state.rd_valid = host_i.rd_en;
      if (host_i.rd_en) begin
         if (host_i.addr == ADDR_REGULATION_STATE) begin // RULE17
            next_state.rd_data = state.image.regulation_state_reg;
         end else if (host_i.addr == ADDR_POWER_THERMAL) begin // RULE17
            next_state.rd_data = state.image.power_thermal_state_reg;
         end else if (host_i.addr == ADDR_SYNC_DIRECTION) begin // RULE17
            next_state.rd_data = state.image.sync_direction_state_reg;
         end else if (host_i.addr == ADDR_PROTECTION_FAULT) begin // RULE17
            next_state.rd_data = state.image.protection_fault_state_reg;
         end else if (host_i.addr == ADDR_HOST_TIMER_FLAG) begin
            next_state.rd_data = flag_image; // RULE18
         end else begin
            // Offsets outside this bank read as zero.
            next_state.rd_data = REG_RESET_VALUE;
         end
      end
      // Write strobes and write data are deliberately never looked at.  RULE19
   end

   // Register the whole record; reset returns every image to zero.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state <= '0; // RULE17
      end else begin
         state <= next_state;
      end
   end

   // Read outputs come straight from the registered record; the flag output comes from the latch.
   assign rd_data_o                   = state.rd_data;
   assign rd_valid_o                  = state.rd_valid;
   assign host_timer_interrupt_flag_o = flag;

endmodule

// ---- src/conv_status_pkg.sv ----
// Purpose: Shared constants and carrier types for the converter status register bank.
// Assumes: Registers are 8 bits wide and are read over a simple parallel host read port.
// Notes:   Every offset, field position and code used by the logic is named here.
package conv_status_pkg;

   // Register offsets of the status group and of the watchdog flag register.
   localparam logic [7:0] ADDR_REGULATION_STATE  = 8'h21;
   localparam logic [7:0] ADDR_POWER_THERMAL     = 8'h22;
   localparam logic [7:0] ADDR_SYNC_DIRECTION    = 8'h23;
   localparam logic [7:0] ADDR_PROTECTION_FAULT  = 8'h24;
   localparam logic [7:0] ADDR_HOST_TIMER_FLAG   = 8'h25;

   // Every register and the read data resets to this value.
   localparam logic [7:0] REG_RESET_VALUE        = 8'h00;

   // Field positions in the regulation state register.
   localparam int unsigned BIT_ADC_DONE          = 7;
   localparam int unsigned BIT_INPUT_CURRENT     = 6;
   localparam int unsigned BIT_INPUT_VOLTAGE     = 5;
   localparam int unsigned BIT_HOST_TIMER        = 3;
   localparam int unsigned LSB_CONVERTER_STATE   = 0;

   // Field positions in the power and thermal register.
   localparam int unsigned BIT_POWER_GOOD        = 7;
   localparam int unsigned LSB_THERMISTOR        = 4;

   // Field positions in the sync and direction register.
   localparam int unsigned LSB_SYNC_CLOCK        = 4;
   localparam int unsigned BIT_REVERSE           = 2;

   // Field positions in the protection fault register.
   localparam int unsigned BIT_INPUT_UV          = 7;
   localparam int unsigned BIT_INPUT_OV          = 6;
   localparam int unsigned BIT_BATTERY_OC        = 5;
   localparam int unsigned BIT_BATTERY_OV        = 4;
   localparam int unsigned BIT_THERMAL_SHUTDOWN  = 3;
   localparam int unsigned BIT_DRIVER_SUPPLY     = 1;

   // Converter state codes.
   localparam logic [2:0] CONV_NOT_SWITCHING     = 3'h0;
   localparam logic [2:0] CONV_CONSTANT_CURRENT  = 3'h3;
   localparam logic [2:0] CONV_CV_FIRST          = 3'h4;
   localparam logic [2:0] CONV_CV_SECOND         = 3'h5;
   localparam logic [2:0] CONV_CV_THIRD          = 3'h6;

   // Thermistor region codes.
   localparam logic [2:0] TS_NORMAL              = 3'h0;
   localparam logic [2:0] TS_WARM                = 3'h1;
   localparam logic [2:0] TS_COOL                = 3'h2;
   localparam logic [2:0] TS_COLD                = 3'h3;
   localparam logic [2:0] TS_HOT                 = 3'h4;

   // Sync pin state codes.
   localparam logic [1:0] SYNC_NO_CLOCK          = 2'h0;
   localparam logic [1:0] SYNC_VALID_CLOCK       = 2'h1;
   localparam logic [1:0] SYNC_PIN_FAULT         = 2'h2;

   // Live conditions from the analog side, all asynchronous to clk_i.
   typedef struct packed {
      logic       adc_conversion_done;            // Conversion finished.
      logic       hardware_current_limit_pin;     // Regulating on the limit pin.
      logic       programmed_input_current_target;// Regulating on the programmed target.
      logic       forward_input_voltage_limit;    // Forward input voltage loop engaged.
      logic       reverse_system_voltage_target;  // Reverse system voltage loop engaged.
      logic       host_timer_expired;             // Serial host watchdog expired.
      logic [2:0] converter_state;                // Converter state code.
      logic       input_power_good;               // Input power good.
      logic [2:0] thermistor_region;              // Thermistor region code.
      logic [1:0] external_sync_clock_pin;        // Sync pin state code.
      logic       reverse_direction;              // Converter runs in reverse.
      logic       input_undervoltage;             // Input under-voltage protection.
      logic       input_overvoltage;              // Input over-voltage protection.
      logic       battery_overcurrent;            // Battery over-current detected.
      logic       battery_overvoltage;            // Battery over-voltage protection.
      logic       thermal_shutdown;               // Thermal shutdown protection.
      logic       gate_driver_supply_pin;         // Driver supply out of valid range.
      logic       battery_only_mode;              // Running from the battery alone.
   } analog_status_s;

   // One host access on the register port.
   typedef struct packed {
      logic       rd_en;                          // Read strobe, one cycle.
      logic       wr_en;                          // Write strobe, one cycle.
      logic [7:0] addr;                           // Register offset.
      logic [7:0] wr_data;                        // Write data, discarded.
   } host_access_s;

   // Images of the four status registers.
   typedef struct packed {
      logic [7:0] regulation_state_reg;           // Offset 0x21 image.
      logic [7:0] power_thermal_state_reg;        // Offset 0x22 image.
      logic [7:0] sync_direction_state_reg;       // Offset 0x23 image.
      logic [7:0] protection_fault_state_reg;     // Offset 0x24 image.
   } status_image_s;

endpackage

// ---- src/status_input_sync.sv ----
// Purpose: Brings a vector of asynchronous condition inputs into the clk_i domain.
// Assumes: Each bit is an independent level; no bus coherence is needed between bits.
// Notes:   Four flops per bit; a bit changes only once stages two and three agree.
`timescale 1ns/1ps
module status_input_sync
   import conv_status_pkg::*;
#(
   parameter int unsigned WIDTH = 8               // Number of bits carried.
) (
   input  wire logic             clk_i,           // System clock.
   input  wire logic             srst_i,          // Synchronous reset, active high.
   input  wire logic [WIDTH-1:0] async_i,         // Raw levels from the analog side.
   output logic      [WIDTH-1:0] sync_o           // Filtered levels in clk_i domain.
);

   // All state of the synchroniser in one record.
   typedef struct packed {
      logic [WIDTH-1:0] meta;                     // First stage, read only by second.
      logic [WIDTH-1:0] mid;                      // Second stage.
      logic [WIDTH-1:0] last;                     // Third stage.
      logic [WIDTH-1:0] held;                     // Accepted value.
   } sync_state_s;

   sync_state_s state;       // Registered state.
   sync_state_s next_state;  // Next state.

   // A bit moves only when the two settled stages agree, which rejects a single
   // stray sample after a metastable first stage.
   always_comb begin
      next_state.meta = async_i;
      next_state.mid  = state.meta;
      next_state.last = state.mid;
      next_state.held = (state.mid & state.last) | (state.held & (state.mid | state.last));
   end

   // Register the whole record; reset clears every stage.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign sync_o = state.held;

endmodule

// ---- src/host_timer_flag_latch.sv ----
// Purpose: Sticky flag raised on a rising edge of the host timer expired bit.
// Assumes: The clear request is a one-cycle pulse marking a host read of the flag.
// Notes:   A rising edge in the clearing cycle keeps the flag set.
`timescale 1ns/1ps
module host_timer_flag_latch
   import conv_status_pkg::*;
(
   input  wire logic clk_i,                       // System clock.
   input  wire logic srst_i,                      // Synchronous reset, active high.
   input  wire logic status_bit_i,                // Host timer expired bit, synchronous.
   input  wire logic clear_i,                     // Host read of the flag, one cycle.
   output logic      host_timer_interrupt_flag_o  // Sticky flag.
);

   // All state of the latch in one record.
   typedef struct packed {
      logic prev;                                 // Previous status bit for edge detect.
      logic flag;                                 // Sticky flag.
   } flag_state_s;

   flag_state_s state;       // Registered state.
   flag_state_s next_state;  // Next state.

   // Set has priority over clear so an edge seen during the read is not lost.
   always_comb begin
      next_state.prev = status_bit_i;
      next_state.flag = (status_bit_i & ~state.prev) | (state.flag & ~clear_i); // RULE18
   end

   // Register the record.
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign host_timer_interrupt_flag_o = state.flag;

endmodule

// ---- verif/converter_status_properties.sv ----
// Purpose: Concurrent checks on the ports of the status register bank.
// Assumes: One clock domain with the synchronous reset srst_i.
// Notes:   Flag clearing is judged only after eight quiet cycles of the watchdog input.
`timescale 1ns/1ps
module converter_status_properties
   import conv_status_pkg::*;
(
   input wire logic           clk_i, // System clock.
   input wire logic           srst_i, // Synchronous reset, active high.
   input wire analog_status_s conditions_i, // Live analog conditions.
   input wire logic           one_shot_mode_i, // ADC one-shot mode.
   input wire logic           adc_enabled_i, // ADC enabled.
   input wire host_access_s   host_i, // Host access request.
   input wire logic [7:0]     rd_data_o, // Read data.
   input wire logic           rd_valid_o, // Read data valid.
   input wire logic           host_timer_interrupt_flag_o // Sticky watchdog flag.
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic [3:0] quiet;  // Cycles the watchdog input has stayed low.
   wire        flag_read_req = host_i.rd_en && host_i.addr == ADDR_HOST_TIMER_FLAG; // Read of the flag.
   // Saturating count; eight quiet cycles mean no rising edge can still be in flight.
   always_ff @(posedge clk_i) begin
      if (srst_i || conditions_i.host_timer_expired)
         quiet <= 4'h0;
      else if (quiet != 4'hf)
         quiet <= quiet + 4'h1;
   end
   // A read strobe aimed at one offset.
   sequence rd_at(logic [7:0] a);
      host_i.rd_en && host_i.addr == a;
   endsequence
   valid_pulse_a: assert property (host_i.rd_en |=> rd_valid_o)
      else $error("read valid missing");
   valid_idle_a: assert property (!host_i.rd_en |=> !rd_valid_o)
      else $error("stray read valid");
   write_ignored_a: assert property (host_i.wr_en && !host_i.rd_en |=> $stable(rd_data_o))
      else $error("write disturbed read data");
   reset_clear_a: assert property ($fell(srst_i) |-> rd_data_o == REG_RESET_VALUE && !rd_valid_o
      && !host_timer_interrupt_flag_o) else $error("outputs not cleared by reset");
   unmapped_zero_a: assert property (host_i.rd_en && (host_i.addr < ADDR_REGULATION_STATE
      || host_i.addr > ADDR_HOST_TIMER_FLAG) |=> rd_data_o == REG_RESET_VALUE) else $error("unmapped read not zero");
   state_code_a: assert property (rd_at(ADDR_REGULATION_STATE) |=> !rd_data_o[4]
      && !(rd_data_o[2:0] inside {3'h1, 3'h2, 3'h7})) else $error("bad converter state field");
   adc_done_a: assert property (rd_at(ADDR_REGULATION_STATE) ##0
      (!one_shot_mode_i && !$past(one_shot_mode_i)) |=> !rd_data_o[7]) else $error("done shown outside one-shot");
   thermal_code_a: assert property (rd_at(ADDR_POWER_THERMAL) |=> rd_data_o[3:0] == 4'h0
      && rd_data_o[6:4] <= TS_HOT) else $error("bad thermistor register");
   sync_code_a: assert property (rd_at(ADDR_SYNC_DIRECTION) |=> rd_data_o[5:4] != 2'h3
      && {rd_data_o[7:6], rd_data_o[3], rd_data_o[1:0]} == 5'h00) else $error("bad sync register");
   fault_spare_a: assert property (rd_at(ADDR_PROTECTION_FAULT) |=> !rd_data_o[2] && !rd_data_o[0])
      else $error("fault spare bits set");
   flag_read_a: assert property (rd_at(ADDR_HOST_TIMER_FLAG) |=>
      rd_data_o == {4'h0, $past(host_timer_interrupt_flag_o), 3'h0}) else $error("flag read value wrong");
   flag_clear_a: assert property (rd_at(ADDR_HOST_TIMER_FLAG) ##0 (quiet >= 4'h8)
      |=> !host_timer_interrupt_flag_o) else $error("flag not cleared by read");
   flag_sticky_a: assert property (host_timer_interrupt_flag_o && !flag_read_req |=>
      host_timer_interrupt_flag_o) else $error("flag dropped without read");
endmodule

bind converter_status_registers converter_status_properties chk (.clk_i(clk_i), .srst_i(srst_i),
   .conditions_i(conditions_i), .one_shot_mode_i(one_shot_mode_i), .adc_enabled_i(adc_enabled_i), .host_i(host_i),
   .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .host_timer_interrupt_flag_o(host_timer_interrupt_flag_o));

// ---- verif/converter_status_registers_tb.sv ----
// Purpose: Self-checking bench for the converter status register bank.
// Assumes: Conditions settle within ten cycles; the synchroniser needs four.
// Notes:   Conditions come from a fixed-seed shift register, after a few hand-picked corners.
`timescale 1ns/1ps
module converter_status_registers_tb
   import conv_status_pkg::*;
;
   logic           clk_i = 1'b0;                 // System clock.
   logic           srst_i = 1'b1;                // Synchronous reset.
   analog_status_s conditions_i = '0;            // Driven conditions.
   logic           one_shot_mode_i = 1'b0;       // One-shot mode control.
   logic           adc_enabled_i = 1'b0;         // ADC enable control.
   host_access_s   host_i = '0;                  // Host request.
   logic [7:0]     rd_data_o;                    // Read data.
   logic           rd_valid_o;                   // Read valid.
   logic           host_timer_interrupt_flag_o;  // Watchdog flag.
   int             num_errors = 0;               // Mismatches.
   int             comparisons = 0;              // Comparisons made.
   logic [31:0]    lfsr = 32'h6494;              // Random source.
   logic           pend = 1'b0;                  // A read result is due.
   logic [7:0]     pend_e = 8'h00;               // Its expected value.
   logic           flag_m = 1'b0;                // Expected watchdog flag.
   logic           prev_hte = 1'b0;              // Last settled watchdog input.

   converter_status_registers dut (.clk_i(clk_i), .srst_i(srst_i), .conditions_i(conditions_i),
      .one_shot_mode_i(one_shot_mode_i), .adc_enabled_i(adc_enabled_i), .host_i(host_i),
      .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .host_timer_interrupt_flag_o(host_timer_interrupt_flag_o));

   // A 50 ns period gives the 20 MHz system clock.
   always #25 clk_i = ~clk_i;

   // Next value of the shift register.
   function automatic logic [31:0] nx(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Register image expected for settled conditions; reserved input codes read as zero.
   function automatic logic [7:0] exp_reg(input logic [7:0] a, input analog_status_s c, input logic os, ae);
      logic [2:0] cs;
      cs = (c.converter_state inside {3'h0, [3'h3:3'h6]}) ? c.converter_state : CONV_NOT_SWITCHING;
      case (a)
         ADDR_REGULATION_STATE: return {c.adc_conversion_done & os,
            c.hardware_current_limit_pin | c.programmed_input_current_target,
            c.forward_input_voltage_limit | c.reverse_system_voltage_target, 1'b0, c.host_timer_expired, cs};
         ADDR_POWER_THERMAL: return {c.input_power_good,
            (c.thermistor_region <= TS_HOT) ? c.thermistor_region : TS_NORMAL, 4'h0};
         ADDR_SYNC_DIRECTION: return {2'h0, (c.external_sync_clock_pin == 2'h3) ? SYNC_NO_CLOCK :
            c.external_sync_clock_pin, 1'b0, c.reverse_direction, 2'h0};
         ADDR_PROTECTION_FAULT: return {c.input_undervoltage, c.input_overvoltage, c.battery_overcurrent,
            c.battery_overvoltage, c.thermal_shutdown, 1'b0,
            c.gate_driver_supply_pin | (c.battery_only_mode & ~ae), 1'b0};
         default: return REG_RESET_VALUE;
      endcase
   endfunction

   // Compare a byte result.
   task automatic chk8(input logic [7:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Compare a single-bit result.
   task automatic chk1(input logic got, exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One host cycle; checks the previous read's result, so reads run back to back.
   task automatic acc(input logic r, w, input logic [7:0] a, d, e);
      @(posedge clk_i);
      host_i <= '{rd_en: r, wr_en: w, addr: a, wr_data: d};
      @(negedge clk_i);
      if (pend) begin
         chk1(rd_valid_o, 1'b1);
         chk8(rd_data_o, pend_e);
      end
      pend = r;
      pend_e = e;
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Ends a hang at several times the expected run length.
   initial begin
      #(50 * 20000);
      num_errors++;
      wrap_up();
   end

   // Main sequence: corners first, then random conditions, with one reset in mid-run.
   initial begin
      analog_status_s c;
      logic [23:0]    v;
      logic [7:0]     ad [7];
      repeat (16) @(posedge clk_i);
      srst_i <= 1'b0;
      for (int i = 0; i < 160; i++) begin
         lfsr = nx(lfsr);
         v = (i == 0) ? 24'hff_ffff : (i == 2) ? 24'h00_0001 : (i == 3) ? 24'h80_0001 : (i == 1) ? 24'h0 : lfsr[23:0];
         c = v[21:0];
         acc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
         // Mid-run reset: reads return zero and the flag drops.
         if (i == 60) begin
            @(posedge clk_i);
            srst_i <= 1'b1;
            conditions_i <= '0;
            repeat (2) @(posedge clk_i);
            srst_i <= 1'b0;
            @(negedge clk_i);
            chk8(rd_data_o, REG_RESET_VALUE);
            chk1(host_timer_interrupt_flag_o, 1'b0);
            flag_m = 1'b0;
            prev_hte = 1'b0;
         end
         @(posedge clk_i);
         conditions_i <= c;
         one_shot_mode_i <= v[22];
         adc_enabled_i <= v[23];
         repeat (10) acc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
         flag_m = flag_m | (!prev_hte && c.host_timer_expired);
         prev_hte = c.host_timer_expired;
         chk1(host_timer_interrupt_flag_o, flag_m);
         acc(1'b0, 1'b1, 8'h21 + {6'h0, lfsr[25:24]}, lfsr[7:0], 8'h00);
         ad = '{8'h20, ADDR_REGULATION_STATE, ADDR_POWER_THERMAL, ADDR_SYNC_DIRECTION, ADDR_PROTECTION_FAULT,
                8'h26, {1'b1, lfsr[30:24]}};
         for (int k = 0; k < 7; k++)
            acc(1'b1, 1'b0, ad[k], 8'h00, exp_reg(ad[k], c, v[22], v[23]));
         // The flag is read on odd passes only, so it also has to survive a pass unread.
         if (i % 2 == 1) begin
            acc(1'b1, 1'b0, ADDR_HOST_TIMER_FLAG, 8'h00, {4'h0, flag_m, 3'h0});
            acc(1'b1, 1'b0, ADDR_HOST_TIMER_FLAG, 8'h00, 8'h00);
            flag_m = 1'b0;
         end
         $display("test %0d done", i);
      end
      acc(1'b0, 1'b0, 8'h00, 8'h00, 8'h00);
      wrap_up();
   end
endmodule
